// ==== shared/sras_pkg.sv ====
// Constants, state types and reset values for the serial register slave
`default_nettype none

package sras_pkg;

  // Fixed device address, upper seven bits of the first byte
  localparam logic [6:0] DEV_ADDR = 7'h75;
  localparam int RW_BIT = 0;
  localparam int STEP_BIT = 6;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT = 4'h1;

  // Pointer register address, read wrap point and reset value
  localparam logic [5:0] PTR_ADDR = 6'h3F;
  localparam logic [5:0] READ_WRAP = 6'h2A;
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [5:0] PTR_ONE = 6'h01;

  // Fastest bus rate the sampling must keep up with
  localparam int MAX_RATE_KBPS = 400;
  localparam int SYS_CLK_MHZ = 50;
  localparam int BIT_PERIOD_NS = 1000000 / MAX_RATE_KBPS;
  localparam int CLK_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  localparam int BIT_CYCLES = BIT_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SRAS_IDLE,
    SRAS_DEV,
    SRAS_RAB,
    SRAS_WDATA,
    SRAS_READ,
    SRAS_IGNORE
  } sras_state_t;

  typedef struct packed {
    sras_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [5:0] ptr;
    logic [5:0] addr;
    logic [7:0] wr_data;
    logic step;
    logic first_rd;
    logic ack_ph;
    logic mst_ack;
    logic mack_n;
    logic ld_req;
    logic wr_en;
    logic rd_en;
    logic sda_oe_n;
  } sras_core_t;

  localparam sras_core_t CORE_RESET = '{
    st: SRAS_IDLE, bitcnt: 4'h0, shreg: 8'h00, tx: 8'h00,
    ptr: PTR_RESET, addr: 6'h00, wr_data: 8'h00, step: 1'b0,
    first_rd: 1'b1, ack_ph: 1'b0, mst_ack: 1'b0, mack_n: 1'b1,
    ld_req: 1'b0, wr_en: 1'b0, rd_en: 1'b0, sda_oe_n: 1'b1
  };

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } sras_sync_t;

  localparam sras_sync_t SYNC_RESET = '{default: 1'b1};

endpackage

`default_nettype wire

// ==== shared/sras_if.sv ====
// Synchronised bus levels and bus events passed from sampler to core
`timescale 1ns/1ps
`default_nettype none

interface sras_if;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport sync_mp (
    output scl_lvl,
    output sda_lvl,
    output scl_rise,
    output scl_fall,
    output start,
    output stop
  );

  modport core_mp (
    input scl_lvl,
    input sda_lvl,
    input scl_rise,
    input scl_fall,
    input start,
    input stop
  );
endinterface

`default_nettype wire

// ==== verilog/sras_sync.sv ====
// Two-stage pin synchroniser with clock edge and start/stop detection
`timescale 1ns/1ps
`default_nettype none

module sras_sync
  import sras_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  sras_if.sync_mp sif
);

  sras_sync_t sync;
  sras_sync_t next_sync;

  always_comb
  begin
    next_sync = sync;
    next_sync.scl_m = serial_clock_line;
    next_sync.scl_s = sync.scl_m;
    next_sync.scl_d = sync.scl_s;
    next_sync.sda_m = serial_data_line_in;
    next_sync.sda_s = sync.sda_m;
    next_sync.sda_d = sync.sda_s;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sync <= SYNC_RESET;
    else
      sync <= next_sync;
  end

  assign sif.scl_lvl = sync.scl_s;
  assign sif.sda_lvl = sync.sda_s;
  assign sif.scl_rise = sync.scl_s & ~sync.scl_d;
  assign sif.scl_fall = ~sync.scl_s & sync.scl_d;
  // Data edges only count while the clock stays high
  assign sif.start = sync.scl_s & sync.scl_d & sync.sda_d & ~sync.sda_s;
  assign sif.stop = sync.scl_s & sync.scl_d & ~sync.sda_d & sync.sda_s;

endmodule // sras_sync

`default_nettype wire

// ==== verilog/sras_slave.sv ====
// Two-wire serial register access slave with stepping register pointer
`timescale 1ns/1ps
`default_nettype none

module sras_slave
  import sras_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  output logic [5:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  output logic [5:0] register_pointer,
  output logic pointer_step_enable
);

  sras_if sif ();

  // Clock line is only ever sampled, never driven
  sras_sync sras_sync_i (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .serial_clock_line(serial_clock_line),
    .serial_data_line_in(serial_data_line_in),
    .sif(sif)
  );

  sras_core_t core;
  sras_core_t next_core;
  logic [7:0] rd_byte;

  // Pointer step ahead of a stepping read
  function automatic logic [5:0] step_read(input logic [5:0] p);
    if (p == READ_WRAP)
      return PTR_RESET;
    else
      return p + PTR_ONE;
  endfunction

  // The pointer register itself answers at its own address
  always_comb
  begin
    if (core.addr == PTR_ADDR)
      rd_byte = {2'b00, core.ptr};
    else
      rd_byte = reg_rd_data;
  end

  always_comb
  begin
    next_core = core;
    next_core.wr_en = 1'b0;
    next_core.rd_en = 1'b0;
    if (sif.start)
    begin
      // Restart aborts whatever byte was in flight
      next_core.st = SRAS_DEV;
      next_core.bitcnt = 4'h0;
      next_core.ack_ph = 1'b0;
      next_core.ld_req = 1'b0;
      next_core.sda_oe_n = 1'b1;
    end
    else if (sif.stop)
    begin
      next_core.st = SRAS_IDLE;
      next_core.bitcnt = 4'h0;
      next_core.ack_ph = 1'b0;
      next_core.ld_req = 1'b0;
      next_core.sda_oe_n = 1'b1;
    end
    else
    begin
      if (core.ld_req)
      begin
        next_core.ld_req = 1'b0;
        next_core.rd_en = 1'b1;
        next_core.addr = core.ptr;
      end
      if (core.rd_en)
      begin
        // Register data arrives while the clock is still low
        next_core.sda_oe_n = rd_byte[7];
        next_core.tx = {rd_byte[6:0], 1'b0};
        next_core.bitcnt = FIRST_TX_BIT;
      end
      if (sif.scl_rise)
      begin
        if (core.ack_ph)
          next_core.mack_n = sif.sda_lvl;
        else if (core.st == SRAS_DEV || core.st == SRAS_RAB ||
                 core.st == SRAS_WDATA)
        begin
          next_core.shreg = {core.shreg[6:0], sif.sda_lvl};
          next_core.bitcnt = core.bitcnt + 4'h1;
        end
      end
      if (sif.scl_fall)
      begin
        if (core.ack_ph)
        begin
          next_core.ack_ph = 1'b0;
          next_core.sda_oe_n = 1'b1;
          if (core.st == SRAS_READ)
          begin
            if (core.mst_ack && core.mack_n)
              next_core.st = SRAS_IGNORE;
            else
            begin
              next_core.ld_req = 1'b1;
              next_core.first_rd = 1'b0;
              if (core.step && !core.first_rd)
                next_core.ptr = step_read(core.ptr);
              else
                next_core.ptr = core.ptr;
            end
          end
        end
        else if (core.st == SRAS_READ)
        begin
          if (core.bitcnt == BYTE_DONE)
          begin
            // Free the line for the master's acknowledge
            next_core.sda_oe_n = 1'b1;
            next_core.ack_ph = 1'b1;
            next_core.mst_ack = 1'b1;
            next_core.bitcnt = 4'h0;
          end
          else
          begin
            next_core.sda_oe_n = core.tx[7];
            next_core.tx = {core.tx[6:0], 1'b0};
            next_core.bitcnt = core.bitcnt + 4'h1;
          end
        end
        else if (core.bitcnt == BYTE_DONE)
        begin
          next_core.bitcnt = 4'h0;
          next_core.mst_ack = 1'b0;
          case (core.st)
            SRAS_DEV:
            begin
              if (core.shreg[7:1] == DEV_ADDR)
              begin
                next_core.ack_ph = 1'b1;
                next_core.sda_oe_n = 1'b0;
                if (core.shreg[RW_BIT])
                  next_core.st = SRAS_READ;
                else
                  next_core.st = SRAS_RAB;
              end
              else
                next_core.st = SRAS_IGNORE;
            end
            SRAS_RAB:
            begin
              next_core.ack_ph = 1'b1;
              next_core.sda_oe_n = 1'b0;
              next_core.ptr = core.shreg[5:0];
              next_core.step = core.shreg[STEP_BIT];
              next_core.first_rd = 1'b1;
              next_core.st = SRAS_WDATA;
            end
            SRAS_WDATA:
            begin
              next_core.ack_ph = 1'b1;
              next_core.sda_oe_n = 1'b0;
              if (core.ptr == PTR_ADDR)
                next_core.ptr = core.shreg[5:0];
              else
              begin
                next_core.wr_en = 1'b1;
                next_core.addr = core.ptr;
                next_core.wr_data = core.shreg;
                if (core.step)
                  next_core.ptr = core.ptr + PTR_ONE;
              end
              if (!core.step)
                next_core.st = SRAS_RAB;
            end
            default:
            begin
              next_core.st = core.st;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      core <= CORE_RESET;
    else
      core <= next_core;
  end

  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_n = core.sda_oe_n;
  assign reg_addr = core.addr;
  assign reg_wr_en = core.wr_en;
  assign reg_wr_data = core.wr_data;
  assign reg_rd_en = core.rd_en;
  assign register_pointer = core.ptr;
  assign pointer_step_enable = core.step;

  // Helper terms for the checks below
  logic byte_end;
  logic [5:0] rab_field;
  logic rab_step;
  logic rd_ack_end;
  assign byte_end = sif.scl_fall && !core.ack_ph &&
    core.bitcnt == BYTE_DONE && !sif.start && !sif.stop;
  assign rab_field = core.shreg[5:0];
  assign rab_step = core.shreg[STEP_BIT];
  assign rd_ack_end = sif.scl_fall && core.ack_ph &&
    core.st == SRAS_READ && !sif.start && !sif.stop &&
    !(core.mst_ack && core.mack_n);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  AST_START_DEV: assert property (
    sif.start |=> core.st == SRAS_DEV && core.sda_oe_n && !core.ack_ph)
    else $error("start did not arm address reception");

  AST_STOP_IDLE: assert property (
    sif.stop && !sif.start |=> core.st == SRAS_IDLE && core.sda_oe_n)
    else $error("stop did not return to idle");

  AST_SDA_CLK_LOW: assert property (
    $changed(core.sda_oe_n) && !$past(sif.start) && !$past(sif.stop)
      |-> !sif.scl_lvl)
    else $error("data line moved while clock high");

  AST_ADDR_MATCH: assert property (
    byte_end && core.st == SRAS_DEV && core.shreg[7:1] == DEV_ADDR
      |=> core.ack_ph && !core.sda_oe_n)
    else $error("matching address not acknowledged");

  AST_DIRECTION: assert property (
    byte_end && core.st == SRAS_DEV && core.shreg[7:1] == DEV_ADDR
      |=> core.st == ($past(core.shreg[RW_BIT]) ? SRAS_READ : SRAS_RAB))
    else $error("direction bit not honoured");

  AST_NO_MATCH: assert property (
    byte_end && core.st == SRAS_DEV && core.shreg[7:1] != DEV_ADDR
      |=> core.st == SRAS_IGNORE && core.sda_oe_n [*2])
    else $error("foreign address was acknowledged");

  AST_RAB_LOAD: assert property (
    byte_end && core.st == SRAS_RAB
      |=> core.ptr == $past(rab_field) && core.step == $past(rab_step)
        && core.st == SRAS_WDATA)
    else $error("register address byte not loaded");

  AST_WR_STEP: assert property (
    byte_end && core.st == SRAS_WDATA && core.step && core.ptr != PTR_ADDR
      |=> core.wr_en && core.addr == $past(core.ptr)
        && core.ptr == $past(core.ptr) + PTR_ONE)
    else $error("stepping write did not advance pointer");

  AST_WR_HOLD: assert property (
    byte_end && core.st == SRAS_WDATA && !core.step && core.ptr != PTR_ADDR
      |=> core.wr_en && core.ptr == $past(core.ptr) && core.st == SRAS_RAB)
    else $error("alternating write moved pointer");

  AST_RESEED: assert property (
    byte_end && core.st == SRAS_WDATA && core.ptr == PTR_ADDR
      |=> !core.wr_en && core.ptr == $past(rab_field))
    else $error("pointer at top was not reseeded");

  AST_WR_ACK: assert property (
    byte_end && core.st != SRAS_READ && core.st != SRAS_IGNORE &&
      core.st != SRAS_IDLE && !(core.st == SRAS_DEV &&
      core.shreg[7:1] != DEV_ADDR)
      |=> !core.sda_oe_n throughout (!sif.scl_fall [*1] ##1 1'b1))
    else $error("write byte acknowledge dropped");

  AST_ACK_HIGH: assert property (
    core.ack_ph && !core.mst_ack && sif.scl_lvl |-> !core.sda_oe_n)
    else $error("write acknowledge released while clock high");

  AST_RD_FIRST: assert property (
    rd_ack_end && core.first_rd |=> core.ptr == $past(core.ptr)
      ##1 core.rd_en && core.addr == core.ptr)
    else $error("first read after address moved pointer");

  AST_RD_HOLD: assert property (
    rd_ack_end && !core.step |=> core.ptr == $past(core.ptr))
    else $error("alternating read moved pointer");

  AST_RD_WRAP: assert property (
    rd_ack_end && core.step && !core.first_rd && core.ptr == READ_WRAP
      |=> core.ptr == PTR_RESET)
    else $error("stepping read did not wrap");

  AST_RD_ADDR: assert property (
    core.rd_en |-> core.addr == core.ptr ##1 core.bitcnt == FIRST_TX_BIT)
    else $error("read not taken from pointer");

  AST_NACK_FREE: assert property (
    sif.scl_fall && core.ack_ph && core.st == SRAS_READ && core.mst_ack &&
      core.mack_n && !sif.start && !sif.stop
      |=> core.st == SRAS_IGNORE && core.sda_oe_n)
    else $error("line held after master no-acknowledge");

  COV_WRITE: cover property (core.wr_en && core.step);
  COV_READ: cover property (core.rd_en ##[1:1000] core.ack_ph && core.mst_ack);
  COV_WRAP: cover property (rd_ack_end && core.step && core.ptr == READ_WRAP);
  COV_RESEED: cover property (
    byte_end && core.st == SRAS_WDATA && core.ptr == PTR_ADDR);

endmodule // sras_slave

`default_nettype wire

// ==== verification/sras_master.sv ====
// Behavioural two-wire bus master for the serial register slave
`timescale 1ns/1ps
`default_nettype none

module sras_master
(
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One bus clock phase lasts four system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Start from an idle bus, or repeated start inside a frame
  task automatic start();
    tick(2);
    if (scl === 1'b0)
    begin
      tick(2);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(2);
      sda_low <= 1'b1;
    end
    else
    begin
      sda_low <= 1'b1;
    end
    tick(2);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(4);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_low <= 1'b0;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      tick(2);
      sda_low <= ~b[i];
      tick(2);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
    end
    tick(2);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    ack = ~sda;
    scl <= 1'b0;
  endtask

  // Extra low time before the byte lets the slave load its first bit
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    tick(4);
    for (int i = 7; i >= 0; i--)
    begin
      tick(4);
      scl <= 1'b1;
      tick(4);
      b[i] = sda;
      scl <= 1'b0;
    end
    tick(2);
    sda_low <= ack_it;
    tick(2);
    scl <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b0;
  endtask
endmodule // sras_master

`default_nettype wire

// ==== verification/serial_register_access_slave_test.sv ====
// Self-checking bench for the serial register access slave
`timescale 1ns/1ps
`default_nettype none

module serial_register_access_slave_test;
  logic sys_clk;
  logic reset_n;
  logic scl;
  logic m_low;
  logic sda_out;
  logic sda_oe_n;
  logic [5:0] reg_addr;
  logic reg_wr_en;
  logic [7:0] reg_wr_data;
  logic reg_rd_en;
  logic [7:0] reg_rd_data;
  logic [5:0] ptr;
  logic step;
  logic [7:0] regs [64];
  wire logic sda_wire;
  int fails = 0;
  int n_tests = 0;
  int n_rd = 0;

  // Wired-AND line with pull-up
  assign sda_wire = ~m_low & (sda_oe_n | sda_out);
  assign reg_rd_data = regs[reg_addr];

  always @(posedge sys_clk)
  begin
    if (reg_wr_en === 1'b1)
      regs[reg_addr] <= reg_wr_data;
    if (reg_rd_en === 1'b1)
      n_rd <= n_rd + 1;
  end

  sras_master sras_master_i (
    .clk(sys_clk),
    .scl(scl),
    .sda_low(m_low),
    .sda(sda_wire)
  );

  sras_slave sras_slave_i (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .serial_clock_line(scl),
    .serial_data_line_in(sda_wire),
    .serial_data_line_out(sda_out),
    .serial_data_line_oe_n(sda_oe_n),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data),
    .register_pointer(ptr),
    .pointer_step_enable(step)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Write-direction address byte then register address byte
  task automatic addr_phase(input logic [7:0] register_address_byte);
    logic ack;
    sras_master_i.start();
    sras_master_i.send_byte(8'hEA, ack);
    check({7'h00, ack}, 8'h01);
    sras_master_i.send_byte(register_address_byte, ack);
    check({7'h00, ack}, 8'h01);
  endtask

  task automatic sc_reset();
    check({2'b00, ptr}, 8'h00);
    check({7'h00, step}, 8'h00);
    check({7'h00, sda_oe_n}, 8'h01);
  endtask

  task automatic sc_bad_addr();
    logic ack;
    sras_master_i.start();
    sras_master_i.send_byte(8'hE8, ack);
    check({7'h00, ack}, 8'h00);
    sras_master_i.send_byte(8'h10, ack);
    check({7'h00, ack}, 8'h00);
    sras_master_i.stop();
    check({2'b00, ptr}, 8'h00);
  endtask

  task automatic sc_step_read();
    logic ack;
    logic [7:0] b;
    logic [5:0] seq [4] = '{6'h28, 6'h29, 6'h2A, 6'h00};
    int rd0;
    rd0 = n_rd;
    addr_phase(8'hE8);
    check({7'h00, step}, 8'h01);
    check({2'b00, ptr}, 8'h28);
    sras_master_i.start();
    sras_master_i.send_byte(8'hEB, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      sras_master_i.recv_byte(i < 3, b);
      check(b, {2'b00, seq[i]} ^ 8'hA5);
    end
    check({7'h00, sda_oe_n}, 8'h01);
    check(8'(n_rd - rd0), 8'h04);
    sras_master_i.stop();
    check({2'b00, ptr}, 8'h00);
  endtask

  task automatic sc_alt_read();
    logic ack;
    logic [7:0] b;
    int rd0;
    rd0 = n_rd;
    addr_phase(8'h05);
    check({7'h00, step}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      sras_master_i.start();
      sras_master_i.send_byte(8'hEB, ack);
      check({7'h00, ack}, 8'h01);
      sras_master_i.recv_byte(1'b0, b);
      check(b, 8'hA0);
    end
    sras_master_i.stop();
    check({2'b00, ptr}, 8'h05);
    check(8'(n_rd - rd0), 8'h02);
  endtask

  task automatic sc_step_write();
    logic ack;
    logic [7:0] dat [4] = '{8'h11, 8'h22, 8'h47, 8'h33};
    addr_phase(8'h7D);
    for (int i = 0; i < 4; i++)
    begin
      sras_master_i.send_byte(dat[i], ack);
      check({7'h00, ack}, 8'h01);
    end
    sras_master_i.stop();
    check(regs[6'h3D], 8'h11);
    check(regs[6'h3E], 8'h22);
    check(regs[6'h3F], 8'h9A);
    check(regs[6'h07], 8'h33);
    check({2'b00, ptr}, 8'h08);
  endtask

  task automatic sc_alt_write();
    logic ack;
    logic [7:0] dat [3] = '{8'h5A, 8'h12, 8'hC3};
    addr_phase(8'h10);
    for (int i = 0; i < 3; i++)
    begin
      sras_master_i.send_byte(dat[i], ack);
      check({7'h00, ack}, 8'h01);
    end
    check({2'b00, ptr}, 8'h12);
    sras_master_i.stop();
    check(regs[6'h10], 8'h5A);
    check(regs[6'h12], 8'hC3);
    check({2'b00, ptr}, 8'h12);
  endtask

  // The pointer register reads back its own value
  task automatic sc_ptr_read();
    logic ack;
    logic [7:0] b;
    addr_phase(8'h3F);
    check({2'b00, ptr}, 8'h3F);
    sras_master_i.start();
    sras_master_i.send_byte(8'hEB, ack);
    check({7'h00, ack}, 8'h01);
    sras_master_i.recv_byte(1'b0, b);
    check(b, 8'h3F);
    sras_master_i.stop();
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    reset_n = 1'b0;
    for (int i = 0; i < 64; i++)
      regs[i] = 8'(i) ^ 8'hA5;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sc_reset();
    sc_bad_addr();
    sc_step_read();
    sc_alt_read();
    sc_step_write();
    sc_alt_write();
    sc_ptr_read();
    tally_and_finish();
  end
endmodule // serial_register_access_slave_test

`default_nettype wire
